// File: hw/hamming_codec.sv
// Hamming single-error-correcting encoder and decoder.
// Assumes a plain data word of width DW; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module hamming_codec #(
  parameter int DW = 19,
  parameter int PW = 5
) (
  input  wire logic [DW-1:0]    encIn,
  output logic      [DW+PW-1:0] encOut,
  input  wire logic [DW+PW-1:0] decIn,
  output logic      [DW-1:0]    decOut
);
  localparam int CW = DW + PW;

  // Spread data over non-power-of-two positions, parity on powers of two
  always_comb begin
    logic [CW:1] code;
    logic [CW:1] fixed;
    logic [PW-1:0] syn;
    int d;
    code = '0;
    fixed = '0;
    syn = '0;
    d = 0;
    for (int p = 1; p <= CW; p++) begin
      if ((p & (p - 1)) != 0) begin
        code[p] = encIn[d];
        d++;
      end
    end
    for (int k = 0; k < PW; k++) begin
      for (int p = 1; p <= CW; p++) begin
        if ((p & (1 << k)) != 0 && p != (1 << k)) begin
          code[1 << k] = code[1 << k] ^ code[p];
        end
      end
    end
    encOut = code;
    // Syndrome points at the flipped position, zero when clean
    fixed = decIn;
    for (int p = 1; p <= CW; p++) begin
      if (decIn[p-1]) begin
        syn = syn ^ PW'(p);
      end
    end
    for (int p = 1; p <= CW; p++) begin
      if (syn == PW'(p)) begin
        fixed[p] = ~fixed[p];
      end
    end
    d = 0;
    decOut = '0;
    for (int p = 1; p <= CW; p++) begin
      if ((p & (p - 1)) != 0) begin
        decOut[d] = fixed[p];
        d++;
      end
    end
  end
endmodule : hamming_codec
`default_nettype wire

// File: hw/trig_table_map.svh
// Constants for the trigger bookkeeping table.
// Assumes inclusion by bare name from the design files.
`ifndef TRIG_TABLE_MAP_SVH
`define TRIG_TABLE_MAP_SVH
`define TT_DEPTH        32
`define TT_IDX_W        5
`define TT_USER_W       5
`define TT_POS_W        2
`define TT_TAG_W        7
`define TT_XING_W       12
`define TT_XING_RESET   12'h000
`define TT_PTR_RESET    6'h00
`define TT_CLOCK_MHZ    40
`endif

// File: hw/trig_table_pkg.sv
// Types for the trigger bookkeeping table.
// Assumes trig_table_map.svh is on the include path.
`include "trig_table_map.svh"
package trig_table_pkg;
  // Trigger request as presented by the decoder; the pads use their own ports
  typedef struct packed {
    logic                   pulse;
    logic [`TT_USER_W-1:0]  userCode;
    logic [`TT_POS_W-1:0]   position;
  } trig_req_s;
  // One row as handed to the data readout
  typedef struct packed {
    logic [`TT_IDX_W-1:0]   rowIndex;
    logic [`TT_TAG_W-1:0]   tag;
    logic [`TT_XING_W-1:0]  crossingIndex;
  } tt_row_s;
endpackage : trig_table_pkg

// File: hw/trigger_bookkeeping_table.sv
// Trigger bookkeeping table: allocates rows per trigger, hands them out FIFO.
// Assumes all inputs come from logic on the crossing clock, except the pads.
`timescale 1ns/1ps
`default_nettype none
`include "trig_table_map.svh"
module trigger_bookkeeping_table #(
  parameter int DEPTH  = `TT_DEPTH,
  parameter int IDX_W  = `TT_IDX_W,
  parameter int XING_W = `TT_XING_W
) (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire trig_table_pkg::trig_req_s decoderTrig,
  input  wire logic                      padTrigPulse,
  input  wire logic [`TT_USER_W-1:0]     padUserCode,
  input  wire logic                      decoderBypass,
  input  wire logic                      crossing_counter_reset_cmd,
  input  wire logic                      datapath_reset_cmd,
  output logic                           matrixTrigPulse,
  output logic      [IDX_W-1:0]          matrixTrigId,
  output logic                           rowValid,
  output trig_table_pkg::tt_row_s        rowData,
  input  wire logic                      rowDone,
  output logic                           overflow,
  output logic      [IDX_W:0]            rowCount
);
  localparam int DW = `TT_TAG_W + XING_W;
  localparam int PW = 5;
  localparam int CW = DW + PW;
  localparam int PTR_W = IDX_W + 1;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0][PTR_W-1:0]  wrPtr;
    logic [2:0][PTR_W-1:0]  rdPtr;
    logic [2:0][XING_W-1:0] xing;
    logic [1:0]             padSync;
    logic [1:0][`TT_USER_W-1:0] padCodeSync;
    logic                   trigOut;
    logic [IDX_W-1:0]       trigId;
    logic                   ovf;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic [CW-1:0] mem [DEPTH];

  // ---------------------------------------------------------------
  // Majority voting
  // ---------------------------------------------------------------
  logic [PTR_W-1:0]  wrVote;
  logic [PTR_W-1:0]  rdVote;
  logic [XING_W-1:0] xingVote;

  // Voted copies correct any single upset copy each clock
  assign wrVote   = (state_reg.wrPtr[0] & state_reg.wrPtr[1]) |
                    (state_reg.wrPtr[1] & state_reg.wrPtr[2]) |
                    (state_reg.wrPtr[0] & state_reg.wrPtr[2]);
  assign rdVote   = (state_reg.rdPtr[0] & state_reg.rdPtr[1]) |
                    (state_reg.rdPtr[1] & state_reg.rdPtr[2]) |
                    (state_reg.rdPtr[0] & state_reg.rdPtr[2]);
  assign xingVote = (state_reg.xing[0] & state_reg.xing[1]) |
                    (state_reg.xing[1] & state_reg.xing[2]) |
                    (state_reg.xing[0] & state_reg.xing[2]);

  // ---------------------------------------------------------------
  // Trigger selection and acceptance
  // ---------------------------------------------------------------
  logic                  padRise;
  logic                  trigIn;
  logic [`TT_TAG_W-1:0]  trigTag;
  logic                  isFull;
  logic                  isEmpty;
  logic                  accept;
  logic                  drain;
  logic [CW-1:0]         encWord;
  logic [DW-1:0]         decWord;

  // Pad pulse after two flops; pads carry no position, so it reads zero
  assign padRise = state_reg.padSync[1];
  assign trigIn  = decoderBypass ? padRise : decoderTrig.pulse;
  // Pad code rides the same two flops as the pad pulse, so they stay paired
  assign trigTag = decoderBypass ? {state_reg.padCodeSync[1], `TT_POS_W'(0)}
                                 : {decoderTrig.userCode, decoderTrig.position};
  assign isEmpty = (wrVote == rdVote);
  assign isFull  = (wrVote[IDX_W-1:0] == rdVote[IDX_W-1:0]) &&
                   (wrVote[IDX_W] != rdVote[IDX_W]);
  // A single pulse input means one trigger per clock at most
  assign accept  = trigIn && !isFull && !datapath_reset_cmd;
  assign drain   = rowDone && !isEmpty && !datapath_reset_cmd;

  hamming_codec #(
    .DW (DW),
    .PW (PW)
  ) u_codec (
    .encIn  ({trigTag, xingVote}),
    .encOut (encWord),
    .decIn  (mem[rdVote[IDX_W-1:0]]),
    .decOut (decWord)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.padSync = {state_reg.padSync[0], padTrigPulse};
    state_next.padCodeSync = {state_reg.padCodeSync[0], padUserCode};
    state_next.trigOut = accept;
    state_next.trigId  = wrVote[IDX_W-1:0];
    for (int i = 0; i < 3; i++) begin
      // Wrap is natural binary rollover
      state_next.xing[i] = crossing_counter_reset_cmd ? XING_W'(0)
                                                      : xingVote + XING_W'(1);
      state_next.wrPtr[i] = accept ? wrVote + PTR_W'(1) : wrVote;
      state_next.rdPtr[i] = drain ? rdVote + PTR_W'(1) : rdVote;
    end
    if (trigIn && isFull) begin
      state_next.ovf = 1'b1;
    end
    if (datapath_reset_cmd) begin
      state_next.wrPtr = '0;
      state_next.rdPtr = '0;
      state_next.ovf   = 1'b0;
      state_next.trigOut = 1'b0;
    end
  end

  // Register the whole state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Table storage
  // ---------------------------------------------------------------
  // Rows kept in plain flops; a row is zeroed when it is read out
  generate
    for (genvar g = 0; g < DEPTH; g++) begin : g_row
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          mem[g] <= '0;
        end else if (datapath_reset_cmd) begin
          mem[g] <= '0;
        end else if (accept && wrVote[IDX_W-1:0] == IDX_W'(g)) begin
          mem[g] <= encWord;
        end else if (drain && rdVote[IDX_W-1:0] == IDX_W'(g)) begin
          mem[g] <= '0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign matrixTrigPulse        = state_reg.trigOut;
  assign matrixTrigId           = state_reg.trigId;
  assign rowValid               = !isEmpty;
  assign rowData.rowIndex       = rdVote[IDX_W-1:0];
  assign rowData.tag            = decWord[DW-1:XING_W];
  assign rowData.crossingIndex  = decWord[XING_W-1:0];
  assign overflow               = state_reg.ovf;
  assign rowCount               = wrVote - rdVote;
endmodule : trigger_bookkeeping_table
`default_nettype wire

// File: verif/trig_readout_model.sv
// Data readout model: consumes the oldest row, promptly or slowly.
// Assumes rowValid and rowDone share the table clock.
`timescale 1ns/1ps
`default_nettype none
module trig_readout_model (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic rowValid,
  input  wire logic drainEn,
  input  wire logic slow,
  output logic      rowDone
);
  logic [1:0] waitCnt;
  // One pulse per row; gap after each so rowValid can settle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rowDone <= 1'b0;
      waitCnt <= 2'h0;
    end else begin
      rowDone <= 1'b0;
      if (drainEn && rowValid && !rowDone) begin
        if (slow && waitCnt != 2'h3) waitCnt <= waitCnt + 2'h1;
        else begin
          rowDone <= 1'b1;
          waitCnt <= 2'h0;
        end
      end
    end
  end
endmodule : trig_readout_model
`default_nettype wire

// File: verif/trig_table_monitor.sv
// Port checker for the trigger bookkeeping table.
// Assumes one clock and binding onto the table instance.
`timescale 1ns/1ps
`default_nettype none
module trig_table_monitor #(
  parameter int DEPTH = 32,
  parameter int IDX_W = 5
) (
  input wire logic                      clock,
  input wire logic                      rst_n,
  input wire trig_table_pkg::trig_req_s decoderTrig,
  input wire logic                      decoderBypass,
  input wire logic                      crossing_counter_reset_cmd,
  input wire logic                      datapath_reset_cmd,
  input wire logic                      matrixTrigPulse,
  input wire logic                      rowValid,
  input wire trig_table_pkg::tt_row_s   rowData,
  input wire logic                      rowDone,
  input wire logic                      overflow,
  input wire logic [IDX_W:0]            rowCount
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic acc;
  // Decoder trigger the table has room for
  assign acc = !decoderBypass && decoderTrig.pulse && rowCount < DEPTH && !datapath_reset_cmd;
  a_accept_fwd: assert property (acc |=> matrixTrigPulse)
    else $error("accepted trigger not forwarded");
  a_count_up: assert property (acc && !rowDone |=> rowCount == $past(rowCount) + 1)
    else $error("row not allocated");
  a_full_drop: assert property (rowCount == DEPTH && decoderTrig.pulse && !decoderBypass
    && !rowDone && !datapath_reset_cmd |=> overflow && !matrixTrigPulse && rowCount == DEPTH)
    else $error("full table took a trigger");
  a_ovf_sticky: assert property (overflow && !datapath_reset_cmd |=> overflow)
    else $error("overflow dropped");
  a_dp_reset: assert property (datapath_reset_cmd |=> rowCount == 0 && !overflow && !rowValid)
    else $error("table not emptied");
  a_valid_count: assert property (rowValid == (rowCount != 0))
    else $error("valid disagrees with count");
  a_tag_fmt: assert property (acc && rowCount == 0 |=>
    rowData.tag == {$past(decoderTrig.userCode), $past(decoderTrig.position)})
    else $error("tag layout wrong");
  a_xing_zero: assert property ($past(crossing_counter_reset_cmd) && acc && rowCount == 0
    |=> rowData.crossingIndex == 0) else $error("crossing counter not reset");
endmodule : trig_table_monitor
bind trigger_bookkeeping_table trig_table_monitor #(.DEPTH(DEPTH), .IDX_W(IDX_W)) u_mon (
  .clock(clock), .rst_n(rst_n), .decoderTrig(decoderTrig), .decoderBypass(decoderBypass),
  .crossing_counter_reset_cmd(crossing_counter_reset_cmd), .rowDone(rowDone),
  .datapath_reset_cmd(datapath_reset_cmd), .matrixTrigPulse(matrixTrigPulse),
  .rowValid(rowValid), .rowData(rowData), .overflow(overflow), .rowCount(rowCount));
`default_nettype wire

// File: verif/trigger_bookkeeping_table_tb.sv
// Self-checking bench for the trigger bookkeeping table.
// Assumes the readout model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module trigger_bookkeeping_table_tb;
  logic clock = 0, rst_n = 0, padTrigPulse = 0, decoderBypass = 0, xingRst = 0, dpRst = 0;
  logic drainEn = 0, slow = 0, matrixTrigPulse, rowValid, rowDone, overflow;
  logic [4:0] padUserCode = 5'h00, matrixTrigId, wp = 5'h00;
  logic [5:0] rowCount;
  logic [11:0] expRow[$]; // Index and tag, oldest first
  trig_table_pkg::trig_req_s decoderTrig = '0;
  trig_table_pkg::tt_row_s rowData;
  int fails = 0, compares = 0;
  always #12.5 clock = ~clock;
  trigger_bookkeeping_table u_dut (.clock(clock), .rst_n(rst_n), .decoderTrig(decoderTrig),
    .padTrigPulse(padTrigPulse), .padUserCode(padUserCode), .decoderBypass(decoderBypass),
    .crossing_counter_reset_cmd(xingRst), .datapath_reset_cmd(dpRst), .rowData(rowData),
    .matrixTrigPulse(matrixTrigPulse), .matrixTrigId(matrixTrigId), .rowValid(rowValid),
    .rowDone(rowDone), .overflow(overflow), .rowCount(rowCount));
  trig_readout_model u_rd (.clock(clock), .rst_n(rst_n), .rowValid(rowValid),
    .drainEn(drainEn), .slow(slow), .rowDone(rowDone));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // Trigger sampled at the next edge; its row joins the expected queue
  task automatic pushTrig(input logic [4:0] u, input logic [1:0] p);
    decoderTrig <= '{1'b1, u, p};
    expRow.push_back({wp, u, p});
    wp++;
  endtask : pushTrig
  // Bounded drain; rows read just after rowDone rises, one edge before they are consumed, must come oldest first
  task automatic drain(input logic s);
    slow <= s;
    drainEn <= 1'b1;
    for (int i = 0; i < 300 && rowCount !== 6'h00; i++) begin
      @(posedge clock);
      #1;
      if (rowDone === 1'b1) chk(rowData[23:12], expRow.pop_front());
    end
    drainEn <= 1'b0;
    chk(rowCount, 6'h00);
  endtask : drain
  task automatic xingTrig(input int n, input logic [11:0] expX);
    @(posedge clock) xingRst <= 1'b1;
    @(posedge clock) xingRst <= 1'b0;
    repeat (n) @(posedge clock);
    pushTrig(5'h15, 2'h3);
    @(posedge clock) decoderTrig.pulse <= 1'b0;
    #1 chk(matrixTrigPulse, 1'b1);
    chk(matrixTrigId, 5'(wp - 1));
    chk(rowData.crossingIndex, expX);
    drain(1'b0);
  endtask : xingTrig
  // Back-to-back triggers one past full; the extra one is dropped
  task automatic fillOver;
    logic [4:0] w0;
    w0 = wp;
    for (int i = 0; i < 33; i++) begin
      @(posedge clock);
      if (i < 32) pushTrig(i[4:0], i[1:0]);
      else decoderTrig <= '{1'b1, 5'h1F, 2'h0};
      #1 if (i > 0) chk(matrixTrigId, 5'(w0 + i - 1));
    end
    @(posedge clock) decoderTrig.pulse <= 1'b0;
    #1 chk(matrixTrigPulse, 1'b0);
    @(posedge clock) #1 chk({overflow, rowCount}, 7'h60);
    drain(1'b1);
    @(posedge clock) dpRst <= 1'b1;
    @(posedge clock) dpRst <= 1'b0;
    #1 chk({overflow, rowValid, rowCount}, 8'h00);
    wp = 5'h00;
  endtask : fillOver
  // Bypass: decoder pulses ignored, pad pulse taken with position zero
  task automatic padTrig;
    @(posedge clock) decoderBypass <= 1'b1;
    padUserCode <= 5'h0A;
    decoderTrig <= '{1'b1, 5'h01, 2'h1};
    @(posedge clock) decoderTrig.pulse <= 1'b0;
    repeat (4) begin
      @(posedge clock);
      #1;
      chk(matrixTrigPulse, 1'b0);
    end
    padTrigPulse <= 1'b1;
    expRow.push_back({5'h00, 5'h0A, 2'h0});
    @(posedge clock) padTrigPulse <= 1'b0;
    for (int i = 0; i < 6 && matrixTrigPulse !== 1'b1; i++) @(posedge clock) #1;
    chk(matrixTrigPulse, 1'b1);
    chk(matrixTrigId, 5'h00);
    decoderBypass <= 1'b0;
    drain(1'b0);
  endtask : padTrig
  // Main sequence; the wrap case lands two past the counter maximum
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    xingTrig(0, 12'h000);
    xingTrig(4097, 12'h001);
    fillOver;
    padTrig;
    results;
  end
endmodule : trigger_bookkeeping_table_tb
`default_nettype wire
